// ===== align_cfg.svh
// Functional notes
// [R1] Sync divider, FIFO, mixers, NCO, meter, correction.
// [R2] Every block runs without any sync.
// [R3] Global mode is active after reset.
// [R4] Pin rising edge syncs all, internal order.
// [R5] Serial source: trigger bit 0-1 starts global.
// [R6] Both disables set: only enabled blocks sync.
// [R7] Block trigger is pin or own bit.
// [R8] Sync not needed: written value applies immediately.
// [R9] Sync needed: shadow loads on sync pulse.
// [R10] Host orders divider, FIFO, then the rest.
// [R11] FIFO sync: write pointer 0, read 4.
// [R12] Sync loads offset correction values.
// [R13] Sync loads gain and phase correction.
// [R14] Sync loads NCO frequency and phase.
// [R15] Sync sets NCO accumulator to phase offset.
// [R16] Coarse mixer restarts from programmed phase.
// [R17] Power meter starts after programmed delay.
// [R18] Eight-deep FIFO, pointers four apart.
// [R19] Pointers within two flag collision, mid code.
// [R20] Pin and bits synchronised, edge gives pulse.
`ifndef ALIGN_CFG_SVH
`define ALIGN_CFG_SVH
`define OFS_CTRL      8'h00
`define OFS_BLK_EN    8'h04
`define OFS_BLK_SRC   8'h08
`define OFS_BLK_TRIG  8'h0c
`define OFS_QOFS      8'h10
`define OFS_QGAIN     8'h14
`define OFS_QPHASE    8'h18
`define OFS_NCO_FREQ  8'h1c
`define OFS_NCO_PHASE 8'h20
`define OFS_CMIX      8'h24
`define OFS_PM_DELAY  8'h28
`define OFS_STATUS    8'h2c
`define CTRL_W        10
`define CTRL_TX_DIS   0
`define CTRL_RX_DIS   1
`define CTRL_TX_SRC   2
`define CTRL_RX_SRC   3
`define CTRL_GTRIG    4
`define CTRL_OFS_NEED 5
`define CTRL_GPH_NEED 6
`define CTRL_NCO_NEED 7
`define CTRL_COLL_EN  8
`define CTRL_MUTE_EN  9
`define BLK_N         7
`define BLK_DIV       0
`define BLK_FIFO      1
`define BLK_CMIX      2
`define BLK_NCO       3
`define BLK_PM        4
`define BLK_QGPH      5
`define BLK_QOFS      6
`define BLK_REST_MASK 7'h7c
`define QOFS_B_LSB    16
`define QGAIN_B_LSB   16
`define CMIX_MODE_LSB 2
`define RST_QGAIN     11'h400
`define RST_PM_DELAY  16'h0008
`define FIFO_PTR_W    3
`define FIFO_WR_INIT  3'h0
`define FIFO_RD_INIT  3'h4
`define COLL_GAP      3'h2
`endif

// ===== align_pkg.sv
`include "align_cfg.svh"
package align_pkg;
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'b0001,
    SEQ_DIV  = 4'b0010,
    SEQ_FIFO = 4'b0100,
    SEQ_REST = 4'b1000
  } seq_state_type;

  typedef struct packed {
    logic [10:0] gain_a;
    logic [10:0] gain_b;
    logic [9:0]  phase;
    logic [12:0] ofs_a;
    logic [12:0] ofs_b;
  } qcorr_type;

  typedef struct packed {
    logic [`FIFO_PTR_W-1:0] wr;
    logic [`FIFO_PTR_W-1:0] rd;
    logic                   coll;
    logic                   mute;
  } fifo_state_type;

  typedef struct packed {
    logic                pin_s1;
    logic                pin_s2;
    logic                pin_prev;
    logic                gtrig_prev;
    logic [`CTRL_W-1:0]  ctrl;
    logic [`BLK_N-1:0]   blk_en;
    logic [`BLK_N-1:0]   blk_src;
    logic [`BLK_N-1:0]   blk_trig;
    logic [`BLK_N-1:0]   trig_prev;
    logic [`BLK_N-1:0]   pulse;
    qcorr_type           sh_q;
    qcorr_type           qc;
    logic [31:0]         nco_freq_sh;
    logic [31:0]         nco_freq;
    logic [31:0]         nco_acc;
    logic [19:0]         nco_ph_sh;
    logic [3:0]          cmix_sh;
    logic [1:0]          cmix_step;
    logic [1:0]          div_phase;
    logic [15:0]         pm_delay;
    logic [15:0]         pm_cnt;
    logic                pm_run;
    seq_state_type       seq;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
  } ctl_state_type;
endpackage

// ===== align_fifo_ptrs.sv
`timescale 1ns/1ps
`include "align_cfg.svh"
module align_fifo_ptrs (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  // Controls
  input  wire logic               sync_pulse,
  input  wire logic               wr_adv,
  input  wire logic               rd_adv,
  input  wire logic               coll_en,
  input  wire logic               mute_en,
  // Pointer state
  output align_pkg::fifo_state_type state
);
  import align_pkg::*;

  fifo_state_type         q;
  fifo_state_type         d;
  logic [`FIFO_PTR_W-1:0] gap_f;
  logic [`FIFO_PTR_W-1:0] gap_b;

  always_comb begin
    d = q;
    // Pointers wrap naturally at the eight-entry depth.
    if (sync_pulse) begin
      d.wr = `FIFO_WR_INIT; // see [R11]
      d.rd = `FIFO_RD_INIT; // see [R18]
    end else begin
      d.wr = q.wr + {{(`FIFO_PTR_W-1){1'b0}}, wr_adv};
      d.rd = q.rd + {{(`FIFO_PTR_W-1){1'b0}}, rd_adv};
    end
    gap_f = d.wr - d.rd;
    gap_b = d.rd - d.wr;
    d.coll = coll_en && (gap_f <= `COLL_GAP || gap_b <= `COLL_GAP); // see [R19]
    d.mute = d.coll && mute_en; // see [R19]
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      q <= '{wr: `FIFO_WR_INIT, rd: `FIFO_RD_INIT, coll: 1'b0, mute: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign state = q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  property p_sync_ptrs;
    sync_pulse |=> (q.wr == `FIFO_WR_INIT) && (q.rd == `FIFO_RD_INIT) && !q.coll;
  endproperty
  a_sync_ptrs: assert property (p_sync_ptrs) else $error("FIFO pointers not set on sync"); // see [R11]

  property p_mute_cause;
    q.mute |-> q.coll && $past(mute_en) && $past(coll_en);
  endproperty
  a_mute_cause: assert property (p_mute_cause) else $error("Mid code without collision"); // see [R19]
endmodule

// ===== multichip_sync_control.sv
`timescale 1ns/1ps
`include "align_cfg.svh"
module multichip_sync_control (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Sync source pin
  input  wire logic                 sync_pin,
  // FIFO pointer advance strobes
  input  wire logic                 fifo_wr_adv,
  input  wire logic                 fifo_rd_adv,
  // Block sync pulses and applied settings
  output logic [`BLK_N-1:0]         blk_sync_pulse,
  output logic [1:0]                div_phase,
  output align_pkg::fifo_state_type fifo_state,
  output logic [1:0]                cmix_mode,
  output logic [1:0]                cmix_step,
  output logic [31:0]               nco_freq,
  output logic [31:0]               nco_acc,
  output align_pkg::qcorr_type      qcorr,
  output logic                      pm_run
);
  import align_pkg::*;

  ctl_state_type     q;
  ctl_state_type     d;
  logic              pin_edge;
  logic              gtrig_edge;
  logic              g_on;
  logic              g_src_reg;
  logic              g_start;
  logic              hit;
  logic              wr_en;
  logic [`BLK_N-1:0] fire;
  logic [31:0]       rd_val;

  function automatic logic [`BLK_N-1:0] rise(input logic [`BLK_N-1:0] now,
                                             input logic [`BLK_N-1:0] was);
    return now & ~was;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      `OFS_CTRL, `OFS_BLK_EN, `OFS_BLK_SRC, `OFS_BLK_TRIG, `OFS_QOFS, `OFS_QGAIN,
      `OFS_QPHASE, `OFS_NCO_FREQ, `OFS_NCO_PHASE, `OFS_CMIX, `OFS_PM_DELAY,
      `OFS_STATUS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Only the second synchroniser stage feeds the edge detector.
  assign pin_edge   = rise(`BLK_N'(q.pin_s2), `BLK_N'(q.pin_prev)) != '0; // see [R20]
  assign gtrig_edge = rise(`BLK_N'(q.ctrl[`CTRL_GTRIG]), `BLK_N'(q.gtrig_prev)) != '0;
  assign g_on       = !(q.ctrl[`CTRL_TX_DIS] && q.ctrl[`CTRL_RX_DIS]); // see [R6]
  assign g_src_reg  = q.ctrl[`CTRL_TX_SRC] || q.ctrl[`CTRL_RX_SRC];
  assign g_start    = g_on && (g_src_reg ? gtrig_edge : pin_edge); // see [R4] see [R5]
  assign hit        = mapped(paddr);
  assign wr_en      = psel && penable && q.pready && pwrite && hit;

  // Block-specific triggers are ignored while global mode owns the blocks.
  assign fire = g_on ? '0 : q.blk_en & ((q.blk_src & rise(q.blk_trig, q.trig_prev)) |
                                        (~q.blk_src & {`BLK_N{pin_edge}})); // see [R7]

  always_comb begin
    rd_val = 32'h0;
    case (paddr)
      `OFS_CTRL:      rd_val = 32'(q.ctrl);
      `OFS_BLK_EN:    rd_val = 32'(q.blk_en);
      `OFS_BLK_SRC:   rd_val = 32'(q.blk_src);
      `OFS_BLK_TRIG:  rd_val = 32'(q.blk_trig);
      `OFS_QOFS:      rd_val = {3'h0, q.sh_q.ofs_b, 3'h0, q.sh_q.ofs_a};
      `OFS_QGAIN:     rd_val = {5'h0, q.sh_q.gain_b, 5'h0, q.sh_q.gain_a};
      `OFS_QPHASE:    rd_val = 32'(q.sh_q.phase);
      `OFS_NCO_FREQ:  rd_val = q.nco_freq_sh;
      `OFS_NCO_PHASE: rd_val = 32'(q.nco_ph_sh);
      `OFS_CMIX:      rd_val = 32'(q.cmix_sh);
      `OFS_PM_DELAY:  rd_val = 32'(q.pm_delay);
      `OFS_STATUS:    rd_val = 32'({q.pm_run, q.seq != SEQ_IDLE, fifo_state});
      default:        rd_val = 32'h0;
    endcase
  end

  always_comb begin
    d = q;
    d.pin_s1     = sync_pin;
    d.pin_s2     = q.pin_s1;
    d.pin_prev   = q.pin_s2;
    d.trig_prev  = q.blk_trig;
    d.gtrig_prev = q.ctrl[`CTRL_GTRIG];

    // One wait state: pready rises in the second access cycle.
    d.pready  = 1'b0;
    d.pslverr = 1'b0;
    d.prdata  = 32'h0;
    if (psel && penable && !q.pready) begin
      d.pready  = 1'b1;
      d.pslverr = !hit;
      d.prdata  = pwrite ? 32'h0 : rd_val;
    end
    if (wr_en) begin
      case (paddr)
        `OFS_CTRL:      d.ctrl = pwdata[`CTRL_W-1:0];
        `OFS_BLK_EN:    d.blk_en = pwdata[`BLK_N-1:0];
        `OFS_BLK_SRC:   d.blk_src = pwdata[`BLK_N-1:0];
        `OFS_BLK_TRIG:  d.blk_trig = pwdata[`BLK_N-1:0];
        `OFS_QOFS: begin
          d.sh_q.ofs_a = pwdata[12:0];
          d.sh_q.ofs_b = pwdata[`QOFS_B_LSB +: 13];
        end
        `OFS_QGAIN: begin
          d.sh_q.gain_a = pwdata[10:0];
          d.sh_q.gain_b = pwdata[`QGAIN_B_LSB +: 11];
        end
        `OFS_QPHASE:    d.sh_q.phase = pwdata[9:0];
        `OFS_NCO_FREQ:  d.nco_freq_sh = pwdata;
        `OFS_NCO_PHASE: d.nco_ph_sh = pwdata[19:0];
        `OFS_CMIX:      d.cmix_sh = pwdata[3:0];
        `OFS_PM_DELAY:  d.pm_delay = pwdata[15:0];
        default:        d.ctrl = q.ctrl;
      endcase
    end

    // Global sequence: divider, then FIFO, then all remaining blocks at once.
    d.pulse = fire;
    case (q.seq)
      SEQ_IDLE: begin
        if (g_start) begin
          d.seq = SEQ_DIV; // see [R3]
        end
      end
      SEQ_DIV: begin
        d.pulse[`BLK_DIV] = 1'b1; // see [R1]
        d.seq = SEQ_FIFO;
      end
      SEQ_FIFO: begin
        d.pulse[`BLK_FIFO] = 1'b1; // see [R1]
        d.seq = SEQ_REST;
      end
      SEQ_REST: begin
        d.pulse = d.pulse | `BLK_REST_MASK; // see [R1]
        d.seq = SEQ_IDLE;
      end
      default: d.seq = SEQ_IDLE;
    endcase

    // Free-running counters keep going with no sync ever applied.
    d.div_phase = q.pulse[`BLK_DIV] ? 2'h0 : q.div_phase + 2'h1; // see [R2]
    d.cmix_step = q.pulse[`BLK_CMIX] ? q.cmix_sh[1:0] : q.cmix_step + 2'h1; // see [R16]

    if (q.pulse[`BLK_NCO] || !q.ctrl[`CTRL_NCO_NEED]) begin
      d.nco_freq = q.nco_freq_sh; // see [R14] see [R9]
    end
    if (q.pulse[`BLK_NCO]) begin
      d.nco_acc = {q.nco_ph_sh, 12'h000}; // see [R15]
    end else begin
      d.nco_acc = q.nco_acc + q.nco_freq;
    end

    if (q.pulse[`BLK_QGPH] || !q.ctrl[`CTRL_GPH_NEED]) begin
      d.qc.gain_a = q.sh_q.gain_a; // see [R13]
      d.qc.gain_b = q.sh_q.gain_b;
      d.qc.phase  = q.sh_q.phase;
    end
    if (q.pulse[`BLK_QOFS] || !q.ctrl[`CTRL_OFS_NEED]) begin
      d.qc.ofs_a = q.sh_q.ofs_a; // see [R12] see [R8]
      d.qc.ofs_b = q.sh_q.ofs_b;
    end

    if (q.pulse[`BLK_PM]) begin
      d.pm_cnt = q.pm_delay; // see [R17]
      d.pm_run = 1'b0;
    end else if (!q.pm_run) begin
      if (q.pm_cnt == 16'h0) begin
        d.pm_run = 1'b1;
      end else begin
        d.pm_cnt = q.pm_cnt - 16'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      q             <= '0;
      q.seq         <= SEQ_IDLE;
      q.sh_q.gain_a <= `RST_QGAIN;
      q.sh_q.gain_b <= `RST_QGAIN;
      q.qc.gain_a   <= `RST_QGAIN;
      q.qc.gain_b   <= `RST_QGAIN;
      q.pm_delay    <= `RST_PM_DELAY;
      q.pm_run      <= 1'b1;
    end else begin
      q <= d;
    end
  end

  align_fifo_ptrs u_fifo (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .sync_pulse (q.pulse[`BLK_FIFO]),
    .wr_adv     (fifo_wr_adv),
    .rd_adv     (fifo_rd_adv),
    .coll_en    (q.ctrl[`CTRL_COLL_EN]),
    .mute_en    (q.ctrl[`CTRL_MUTE_EN]),
    .state      (fifo_state)
  );

  assign prdata         = q.prdata;
  assign pready         = q.pready;
  assign pslverr        = q.pslverr;
  assign blk_sync_pulse = q.pulse;
  assign div_phase      = q.div_phase;
  assign cmix_mode      = q.cmix_sh[`CMIX_MODE_LSB +: 2];
  assign cmix_step      = q.cmix_step;
  assign nco_freq       = q.nco_freq;
  assign nco_acc        = q.nco_acc;
  assign qcorr          = q.qc;
  assign pm_run         = q.pm_run;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  property p_global_order;
    (g_start && q.seq == SEQ_IDLE) |=> q.seq == SEQ_DIV ##1 q.pulse[`BLK_DIV]
      ##1 q.pulse[`BLK_FIFO] ##1 (q.pulse & `BLK_REST_MASK) == `BLK_REST_MASK;
  endproperty
  a_global_order: assert property (p_global_order) else $error("Global order broken"); // see [R4]

  property p_reg_trigger;
    (g_on && g_src_reg && gtrig_edge && q.seq == SEQ_IDLE) |=> q.seq == SEQ_DIV;
  endproperty
  a_reg_trigger: assert property (p_reg_trigger) else $error("Trigger bit ignored"); // see [R5]

  property p_blk_only;
    ($past(!g_on) && $past(q.seq) == SEQ_IDLE) |-> (q.pulse & ~$past(q.blk_en)) == '0;
  endproperty
  a_blk_only: assert property (p_blk_only) else $error("Disabled block synced"); // see [R6]

  property p_blk_pin;
    (!g_on && pin_edge)
      |=> (q.pulse & $past(q.blk_en & ~q.blk_src)) == $past(q.blk_en & ~q.blk_src);
  endproperty
  a_blk_pin: assert property (p_blk_pin) else $error("Pin did not sync block"); // see [R7]

  property p_ofs_now;
    (wr_en && paddr == `OFS_QOFS && !q.ctrl[`CTRL_OFS_NEED] && !d.ctrl[`CTRL_OFS_NEED])
      |=> ##1 q.qc.ofs_a == $past(pwdata[12:0], 2);
  endproperty
  a_ofs_now: assert property (p_ofs_now) else $error("Offset not applied at once"); // see [R8]

  property p_ofs_held;
    (q.ctrl[`CTRL_OFS_NEED] && !q.pulse[`BLK_QOFS]) |=> $stable(q.qc.ofs_a);
  endproperty
  a_ofs_held: assert property (p_ofs_held) else $error("Offset changed without sync"); // see [R9]

  property p_nco_init;
    q.pulse[`BLK_NCO] |=> q.nco_acc == {$past(q.nco_ph_sh), 12'h000};
  endproperty
  a_nco_init: assert property (p_nco_init) else $error("NCO not initialised"); // see [R15]

  property p_pm_wait;
    (q.pulse[`BLK_PM] && q.pm_delay == 16'h2) |=> !q.pm_run [*3] ##1 q.pm_run;
  endproperty
  a_pm_wait: assert property (p_pm_wait) else $error("Power meter delay wrong"); // see [R17]

  property p_div_sync;
    q.pulse[`BLK_DIV] |=> q.div_phase == 2'h0;
  endproperty
  a_div_sync: assert property (p_div_sync) else $error("Divider not realigned"); // see [R1]

  property p_cmix_load;
    q.pulse[`BLK_CMIX] |=> q.cmix_step == $past(q.cmix_sh[1:0]);
  endproperty
  a_cmix_load: assert property (p_cmix_load) else $error("Mixer phase not applied"); // see [R16]

  property p_gph_load;
    q.pulse[`BLK_QGPH] |=> q.qc.gain_a == $past(q.sh_q.gain_a)
      && q.qc.gain_b == $past(q.sh_q.gain_b) && q.qc.phase == $past(q.sh_q.phase);
  endproperty
  a_gph_load: assert property (p_gph_load) else $error("Gain or phase not loaded"); // see [R13]

  property p_ofs_load;
    q.pulse[`BLK_QOFS] |=> q.qc.ofs_a == $past(q.sh_q.ofs_a)
      && q.qc.ofs_b == $past(q.sh_q.ofs_b);
  endproperty
  a_ofs_load: assert property (p_ofs_load) else $error("Offset not loaded on sync"); // see [R12]

  property p_nco_load;
    q.pulse[`BLK_NCO] |=> q.nco_freq == $past(q.nco_freq_sh);
  endproperty
  a_nco_load: assert property (p_nco_load) else $error("NCO frequency not loaded"); // see [R14]

  property p_pm_start;
    q.pulse[`BLK_PM] |=> !q.pm_run && q.pm_cnt == $past(q.pm_delay);
  endproperty
  a_pm_start: assert property (p_pm_start) else $error("Power meter not restarted"); // see [R17]
endmodule

// ===== align_sync_source.sv
`timescale 1ns/1ps
module align_sync_source (
  // Clock
  input  wire logic sys_clk,
  // Far-side drives
  output logic      sync_pin,
  output logic      fifo_wr_adv,
  output logic      fifo_rd_adv
);
  initial begin
    sync_pin = 1'b0;
    fifo_wr_adv = 1'b0;
    fifo_rd_adv = 1'b0;
  end
  // The pin stays high for six clocks after each rise, then low for four, so the edge finder never merges two.
  task automatic pin_pulse();
    @(posedge sys_clk);
    sync_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    sync_pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic advance(input logic wr, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      fifo_wr_adv <= wr;
      fifo_rd_adv <= !wr;
    end
    @(posedge sys_clk);
    fifo_wr_adv <= 1'b0;
    fifo_rd_adv <= 1'b0;
  endtask
endmodule

// ===== multichip_sync_control_tb_top.sv
`timescale 1ns/1ps
`include "align_cfg.svh"
module multichip_sync_control_tb_top;
  import align_pkg::*;
  logic              sys_clk;
  logic              nrst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              sync_pin;
  logic              fifo_wr_adv;
  logic              fifo_rd_adv;
  logic [`BLK_N-1:0] blk_sync_pulse;
  logic [1:0]        div_phase;
  fifo_state_type    fifo_state;
  logic [1:0]        cmix_mode;
  logic [1:0]        cmix_step;
  logic [31:0]       nco_freq;
  logic [31:0]       nco_acc;
  qcorr_type         qcorr;
  logic              pm_run;
  int                error_cnt;
  int                n_checks;
  int                cyc;
  int                t0;
  int                t1;
  int                t2;
  int                n0;
  int                pm_low;
  int                dly;
  logic [31:0]       rd;
  logic              err;
  logic [`BLK_N-1:0] seen;
  logic [31:0]       acc1;
  logic [31:0]       acc2;
  logic [1:0]        step1;
  logic [1:0]        div1;
  fifo_state_type    fifo1;
  logic [12:0]       oa;
  logic [12:0]       ob;
  logic [10:0]       ga;
  logic [10:0]       gb;
  logic [9:0]        phq;
  logic [31:0]       fq;
  logic [19:0]       phn;
  logic [3:0]        cm;

  multichip_sync_control dut_u (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sync_pin(sync_pin), .fifo_wr_adv(fifo_wr_adv),
    .fifo_rd_adv(fifo_rd_adv), .blk_sync_pulse(blk_sync_pulse), .div_phase(div_phase),
    .fifo_state(fifo_state), .cmix_mode(cmix_mode), .cmix_step(cmix_step),
    .nco_freq(nco_freq), .nco_acc(nco_acc), .qcorr(qcorr), .pm_run(pm_run));
  align_sync_source partner_u (.sys_clk(sys_clk), .sync_pin(sync_pin),
    .fifo_wr_adv(fifo_wr_adv), .fifo_rd_adv(fifo_rd_adv));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("MISMATCH at %0t: run did not finish", $time);
      summarize();
    end
  end

  function automatic logic [31:0] exp_status(input logic run, input logic [2:0] w,
                                             input logic [2:0] r);
    return {22'h0, run, 1'b0, w, r, 2'b00};
  endfunction

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check_bit(k < 20, 1'b1);
  endtask

  // Records when the divider, FIFO and mixer pulses first show and snapshots the blocks one and two edges after them.
  task automatic watch(input int n);
    seen = '0;
    t0 = -1;
    t1 = -1;
    t2 = -1;
    n0 = 0;
    pm_low = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      #1;
      seen |= blk_sync_pulse;
      if (i == t0 + 1 && t0 >= 0) div1 = div_phase;
      if (i == t1 + 1 && t1 >= 0) fifo1 = fifo_state;
      if (i == t2 + 1 && t2 >= 0) acc1 = nco_acc;
      if (i == t2 + 1 && t2 >= 0) step1 = cmix_step;
      if (i == t2 + 2 && t2 >= 0) acc2 = nco_acc;
      if (t2 >= 0 && pm_run === 1'b0) pm_low++;
      if (blk_sync_pulse[0] === 1'b1) n0++;
      if (blk_sync_pulse[0] === 1'b1 && t0 < 0) t0 = i;
      if (blk_sync_pulse[1] === 1'b1 && t1 < 0) t1 = i;
      if (blk_sync_pulse[2] === 1'b1 && t2 < 0) t2 = i;
    end
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(79));
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    apb(1'b0, `OFS_PM_DELAY, 32'h0);
    check_word(rd, 32'h8);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check_word(rd, exp_status(1'b1, 3'h0, 3'h4));
    apb(1'b0, 8'h30, 32'h0);
    check_word({err, rd[30:0]}, 32'h80000000);
    check_word({21'h0, qcorr.gain_a}, {21'h0, `RST_QGAIN});
    oa = 13'($urandom);
    ob = 13'($urandom);
    fq = $urandom;
    apb(1'b1, `OFS_QOFS, {3'h0, ob, 3'h0, oa});
    apb(1'b1, `OFS_NCO_FREQ, fq);
    repeat (3) @(posedge sys_clk);
    #1;
    check_word({6'h0, qcorr.ofs_b, qcorr.ofs_a}, {6'h0, ob, oa});
    acc1 = nco_acc;
    @(posedge sys_clk);
    #1;
    check_word(nco_acc - acc1, fq);
    // Shortest meter delay used here, a corner that the random draw below never picks.
    apb(1'b1, `OFS_PM_DELAY, 32'h2);
    apb(1'b1, `OFS_CTRL, 32'h300);
    partner_u.advance(1'b1, 2);
    repeat (3) @(posedge sys_clk);
    #1;
    check_word({30'h0, fifo_state.coll, fifo_state.mute}, 32'h3);
    fork
      partner_u.pin_pulse();
      watch(30);
    join
    check_word(seen, 32'h7f);
    check_word(t1 - t0, 32'd1);
    check_word(t2 - t1, 32'd1);
    check_word(n0, 32'd1);
    check_word({30'h0, div1}, 32'h0);
    check_word({fifo1.wr, fifo1.rd, fifo1.coll}, {3'h0, 3'h4, 1'b0});
    check_word(pm_low, 32'd3);
    oa = ~oa;
    ob = 13'($urandom);
    ga = 11'($urandom);
    gb = 11'($urandom);
    phq = 10'($urandom);
    phn = 20'($urandom);
    cm = 4'($urandom);
    dly = 3 + $urandom % 16;
    apb(1'b1, `OFS_CTRL, 32'h0e4);
    apb(1'b1, `OFS_PM_DELAY, 32'(dly));
    apb(1'b1, `OFS_QOFS, {3'h0, ob, 3'h0, oa});
    apb(1'b1, `OFS_QGAIN, {5'h0, gb, 5'h0, ga});
    apb(1'b1, `OFS_QPHASE, {22'h0, phq});
    apb(1'b1, `OFS_NCO_FREQ, ~fq);
    apb(1'b1, `OFS_NCO_PHASE, {12'h0, phn});
    apb(1'b1, `OFS_CMIX, {28'h0, cm});
    repeat (3) @(posedge sys_clk);
    #1;
    check_word({19'h0, qcorr.ofs_a}, {19'h0, ~oa});
    check_word(nco_freq, fq);
    check_word({30'h0, cmix_mode}, {30'h0, cm[3:2]});
    // The trigger write hands the source select over from the transmit to the receive bit.
    fork
      apb(1'b1, `OFS_CTRL, 32'h0f8);
      watch(40);
    join
    check_word(seen, 32'h7f);
    check_word({6'h0, qcorr.ofs_b, qcorr.ofs_a}, {6'h0, ob, oa});
    check_word({10'h0, qcorr.gain_a, qcorr.gain_b}, {10'h0, ga, gb});
    check_word({22'h0, qcorr.phase}, {22'h0, phq});
    check_word(nco_freq, ~fq);
    check_word(acc1, {phn, 12'h0});
    check_word(acc2 - acc1, ~fq);
    check_word({30'h0, step1}, {30'h0, cm[1:0]});
    check_word(pm_low, dly + 1);
    apb(1'b1, `OFS_CTRL, 32'h003);
    apb(1'b1, `OFS_BLK_EN, 32'h03);
    apb(1'b1, `OFS_BLK_SRC, 32'h02);
    apb(1'b1, `OFS_BLK_TRIG, 32'h0);
    // Block mode: the divider from the pin first, then the FIFO from its own bit.
    fork
      partner_u.pin_pulse();
      watch(20);
    join
    check_word(seen, 32'h01);
    fork
      apb(1'b1, `OFS_BLK_TRIG, 32'h02);
      watch(12);
    join
    check_word(seen, 32'h02);
    summarize();
  end
endmodule
